//--- pkg/ser_cfg.svh
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

// ----------------------------------------
// status byte bit positions
// ----------------------------------------
`define SER_STB_A 2
`define SER_STB_B 3
`define SER_STB_MAV 4
`define SER_STB_ESB 5
`define SER_STB_MSS 6

// ----------------------------------------
// standard event latch bit positions
// ----------------------------------------
`define SER_ESR_OPC 0
`define SER_ESR_EXE 4
`define SER_ESR_CME 5

// ----------------------------------------
// reset values, slot ranges, response lengths
// ----------------------------------------
`define SER_MASK_RST 8'h00
`define SER_LATCH_RST 8'h00
`define SER_PSC_RST 1'b0
`define SER_SETUP_LAST 8'h0a
`define SER_SEQ_FIRST 8'h0b
`define SER_SLOTS 256
`define SER_IDN_LEN 49
`define SER_LRN_LEN 202
`define SER_STB_NOBUS 8'h7f
`define SER_ASCII_ZERO 8'h30

`endif

//--- pkg/ser_pkg.sv
package ser_pkg;

	// ----------------------------------------
	// decoded commands from the command parser
	// ----------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_SET_MASK = 4'h1,
		CMD_QRY_MASK = 4'h2,
		CMD_QRY_EVT = 4'h3,
		CMD_CLS = 4'h4,
		CMD_QRY_STB = 4'h5,
		CMD_IDN = 4'h6,
		CMD_IST = 4'h7,
		CMD_LRN = 4'h8,
		CMD_OPC = 4'h9,
		CMD_OPC_Q = 4'ha,
		CMD_PSC = 4'hb,
		CMD_PSC_Q = 4'hc,
		CMD_RCL = 4'hd,
		CMD_SAV = 4'he
	} ser_cmd_t;

	// register selector for mask and event commands
	typedef enum logic [2:0] {
		SEL_STD = 3'h0,
		SEL_A = 3'h1,
		SEL_B = 3'h2,
		SEL_SRE = 3'h3,
		SEL_PPE = 3'h4
	} ser_sel_t;

	// response engine states
	typedef enum logic [1:0] {
		RSP_IDLE = 2'b00,
		RSP_SHORT = 2'b01,
		RSP_IDN = 2'b10,
		RSP_LRN = 2'b11
	} ser_rsp_t;

endpackage : ser_pkg

//--- hw/ser_slot_mem.sv
`include "ser_cfg.svh"

// ----------------------------------------
// battery-backed setup and sequence slots
// ----------------------------------------
module ser_slot_mem #(
	parameter int W = 64,
	parameter int D = `SER_SLOTS
) (
	input wire logic clk, // instrument clock
	input wire logic rst, // async reset, read port only
	input wire logic we, // write strobe
	input wire logic [7:0] addr, // slot number
	input wire logic [W-1:0] wdata, // slot contents to store
	output logic [W-1:0] rdata // registered read data
);

	logic [W-1:0] mem_q [D];

	// storage array, no reset so contents survive
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[addr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem_q[addr];
		end
	end

endmodule : ser_slot_mem

//--- hw/ser_status.sv
// Operation
// (R01) group summary true while any latched bit is also enabled by its mask
// (R02) five 8-bit mask registers, each writable 0..255 and readable
// (R03) masks change only on explicit write, never on query or clear
// (R04) writing zero clears all bits of a mask
// (R05) masks survive power loss, cleared at shutdown only when flag is one
// (R06) event bit sets on rising or falling condition edge per bit
// (R07) a set event bit stays set until read or cleared
// (R08) three 8-bit event latches, read returns value then clears it
// (R09) clear-status clears all three event latches together
// (R10) each event latch has its own mask; two masks gate status byte, poll
// (R11) malformed command sets command-error bit of standard latch
// (R12) identification query returns fixed 49-character comma-separated string
// (R13) individual-status query returns '0' or '1', changing nothing
// (R14) without parallel bus, individual status always answers one
// (R15) learn query returns 202 characters of settings, resendable as commands
// (R16) operation-complete command sets its bit after earlier commands finish
// (R17) operation-complete query queues '1' and message-available after earlier commands
// (R18) power-on clear flag takes 0 or 1, query returns "0" or "1"
// (R19) power-on clear flag persists through power-off and clear
// (R20) recall of slots 1..10 restores the full stored setting set
// (R21) slots 11..255 hold only voltage, current and dwell fields
// (R22) clear-status clears status byte except message-available, cancels request
// (R23) event summaries sit in status byte bits 2, 3 and 5
// (R24) an event arriving during a read-clear is kept set
`include "ser_cfg.svh"

module ser_status #(
	parameter int SET_W = 64,
	parameter int SEQ_W = 40,
	parameter logic [7:0] A_FALL = 8'h00,
	parameter logic [7:0] B_FALL = 8'h00,
	// arbitrary neutral identity string
	parameter logic [`SER_IDN_LEN*8-1:0] IDN_STR = "VENDOR,MODEL-000000000000000000,SN00000000,00.000"
) (
	input wire logic clk, // instrument clock
	input wire logic rst, // async reset, active high
	input wire logic cmd_valid, // decoded command present
	output logic cmd_ready, // command taken when both high
	input wire ser_pkg::ser_cmd_t cmd_code, // command code
	input wire ser_pkg::ser_sel_t cmd_sel, // register selector
	input wire logic [7:0] cmd_arg, // numeric argument
	input wire logic cmd_bad, // malformed command pulse
	input wire logic exec_busy, // earlier commands still executing
	input wire logic [7:0] std_evt, // other standard event pulses
	input wire logic [7:0] a_cond, // event A condition levels
	input wire logic [7:0] b_cond, // event B condition levels
	input wire logic pwr_down, // shutdown pulse
	input wire logic poll_done, // serial poll finished pulse
	input wire logic gpib_fitted, // parallel bus interface present
	output logic rsp_valid, // response character valid
	input wire logic rsp_ready, // response character taken
	output logic [7:0] rsp_data, // response character
	output logic rsp_last, // last character of response
	output logic [7:0] lrn_idx, // learn string character index
	input wire logic [7:0] lrn_char, // learn string character
	output logic [7:0] stb, // serial poll status byte
	output logic srq, // service request
	output logic ist, // individual status message
	input wire logic [SET_W-1:0] settings, // present setting vector
	output logic recall_valid, // recalled settings pulse
	output logic recall_full, // full setup slot recalled
	output logic [SET_W-1:0] recall_data // recalled setting vector
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (SEQ_W >= SET_W || SEQ_W < 1) begin : g_bad_width
		$error("sequence field width does not fit the setting vector");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] std_mask_q, a_mask_q, b_mask_q, sre_mask_q, ppe_mask_q;
	logic psc_q;
	logic [7:0] std_lat_q, a_lat_q, b_lat_q;
	logic [7:0] a_prev_q, b_prev_q;
	logic rqs_q, mss_prev_q;
	logic opc_pend_q, opcq_pend_q;
	ser_pkg::ser_rsp_t rsp_st_q;
	logic [7:0] rsp_idx_q, rsp_len_q;
	logic [23:0] rsp_buf_q;
	logic rcl_q, rcl_full_q;
	logic [SET_W-1:0] mem_rdata;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire cmd_go = cmd_valid & cmd_ready;
	wire cmd_is = cmd_go;
	wire do_set_mask = cmd_is && cmd_code == ser_pkg::CMD_SET_MASK;
	wire do_qry_mask = cmd_is && cmd_code == ser_pkg::CMD_QRY_MASK;
	wire do_qry_evt = cmd_is && cmd_code == ser_pkg::CMD_QRY_EVT;
	wire do_cls = cmd_is && cmd_code == ser_pkg::CMD_CLS;
	wire do_qry_stb = cmd_is && cmd_code == ser_pkg::CMD_QRY_STB;
	wire do_idn = cmd_is && cmd_code == ser_pkg::CMD_IDN;
	wire do_ist = cmd_is && cmd_code == ser_pkg::CMD_IST;
	wire do_lrn = cmd_is && cmd_code == ser_pkg::CMD_LRN;
	wire do_opc = cmd_is && cmd_code == ser_pkg::CMD_OPC;
	wire do_opcq = cmd_is && cmd_code == ser_pkg::CMD_OPC_Q;
	wire do_psc = cmd_is && cmd_code == ser_pkg::CMD_PSC;
	wire do_pscq = cmd_is && cmd_code == ser_pkg::CMD_PSC_Q;
	wire do_rcl = cmd_is && cmd_code == ser_pkg::CMD_RCL;
	wire do_sav = cmd_is && cmd_code == ser_pkg::CMD_SAV;
	wire slot_zero = cmd_arg == 8'h00;
	wire slot_setup = cmd_arg <= `SER_SETUP_LAST;

	// mask write strobes per register
	wire wr_std = do_set_mask && cmd_sel == ser_pkg::SEL_STD;
	wire wr_a = do_set_mask && cmd_sel == ser_pkg::SEL_A;
	wire wr_b = do_set_mask && cmd_sel == ser_pkg::SEL_B;
	wire wr_sre = do_set_mask && cmd_sel == ser_pkg::SEL_SRE;
	wire wr_ppe = do_set_mask && cmd_sel == ser_pkg::SEL_PPE;
	wire nv_wipe = pwr_down & psc_q; // (R05)

	// event latch read-clear strobes
	wire rd_std = do_qry_evt && cmd_sel == ser_pkg::SEL_STD;
	wire rd_a = do_qry_evt && cmd_sel == ser_pkg::SEL_A;
	wire rd_b = do_qry_evt && cmd_sel == ser_pkg::SEL_B;
	wire clr_std = rd_std | do_cls; // (R08) (R09)
	wire clr_a = rd_a | do_cls; // (R08) (R09)
	wire clr_b = rd_b | do_cls; // (R08) (R09)

	// ----------------------------------------
	// edge detection per condition bit
	// ----------------------------------------
	logic [7:0] a_set, b_set;
	genvar gi;
	for (gi = 0; gi < 8; gi++) begin : g_edge
		assign a_set[gi] = A_FALL[gi] ? (a_prev_q[gi] & ~a_cond[gi]) : (~a_prev_q[gi] & a_cond[gi]); // (R06)
		assign b_set[gi] = B_FALL[gi] ? (b_prev_q[gi] & ~b_cond[gi]) : (~b_prev_q[gi] & b_cond[gi]); // (R06)
	end

	// standard event sources
	wire opc_fire = opc_pend_q & ~exec_busy; // (R16)
	wire opcq_fire = opcq_pend_q & ~exec_busy; // (R17)
	wire [7:0] std_set = std_evt
		| (8'(cmd_bad) << `SER_ESR_CME) // (R11)
		| (8'(opc_fire) << `SER_ESR_OPC) // (R16)
		| (8'(do_rcl & slot_zero) << `SER_ESR_EXE);

	// next latch values: set wins over clear
	wire [7:0] std_lat_d = (clr_std ? `SER_LATCH_RST : std_lat_q) | std_set; // (R07) (R24)
	wire [7:0] a_lat_d = (clr_a ? `SER_LATCH_RST : a_lat_q) | a_set; // (R07) (R24)
	wire [7:0] b_lat_d = (clr_b ? `SER_LATCH_RST : b_lat_q) | b_set; // (R07) (R24)

	// ----------------------------------------
	// summaries, status byte, service request
	// ----------------------------------------
	wire std_sum = |(std_lat_q & std_mask_q); // (R01) (R10)
	wire a_sum = |(a_lat_q & a_mask_q); // (R01) (R10)
	wire b_sum = |(b_lat_q & b_mask_q); // (R01) (R10)
	wire mav = rsp_st_q != ser_pkg::RSP_IDLE;
	wire [7:0] stb_core = (8'(a_sum) << `SER_STB_A) | (8'(b_sum) << `SER_STB_B)
		| (8'(mav) << `SER_STB_MAV) | (8'(std_sum) << `SER_STB_ESB); // (R23)
	wire mss = |(stb_core & sre_mask_q); // (R10)
	wire [7:0] stb_full = stb_core | (8'(mss) << `SER_STB_MSS);
	wire [7:0] stb_qry = gpib_fitted ? (stb_full | (8'h01 << `SER_STB_MAV)) : `SER_STB_NOBUS;
	assign stb = stb_core | (8'(rqs_q) << `SER_STB_MSS);
	assign srq = rqs_q;
	assign ist = gpib_fitted ? |(stb_full & ppe_mask_q) : 1'b1; // (R10) (R14)

	// ----------------------------------------
	// short response value and decimal text
	// ----------------------------------------
	function automatic logic [25:0] ser_dec3(input logic [7:0] v);
		logic [7:0] h, t, o;
		h = v / 8'd100;
		t = (v / 8'd10) % 8'd10;
		o = v % 8'd10;
		if (v >= 8'd100) begin
			ser_dec3 = {2'd3, h + `SER_ASCII_ZERO, t + `SER_ASCII_ZERO, o + `SER_ASCII_ZERO};
		end else if (v >= 8'd10) begin
			ser_dec3 = {2'd2, t + `SER_ASCII_ZERO, o + `SER_ASCII_ZERO, 8'h00};
		end else begin
			ser_dec3 = {2'd1, o + `SER_ASCII_ZERO, 16'h0000};
		end
	endfunction : ser_dec3

	logic [7:0] mask_sel, lat_sel, short_val;
	always_comb begin
		case (cmd_sel)
			ser_pkg::SEL_STD: mask_sel = std_mask_q;
			ser_pkg::SEL_A: mask_sel = a_mask_q;
			ser_pkg::SEL_B: mask_sel = b_mask_q;
			ser_pkg::SEL_SRE: mask_sel = sre_mask_q;
			ser_pkg::SEL_PPE: mask_sel = ppe_mask_q;
			default: mask_sel = 8'h00;
		endcase
	end
	assign lat_sel = (cmd_sel == ser_pkg::SEL_A) ? a_lat_q : (cmd_sel == ser_pkg::SEL_B) ? b_lat_q : std_lat_q;
	assign short_val = do_qry_mask ? mask_sel
		: do_qry_evt ? lat_sel // (R08)
		: do_qry_stb ? stb_qry
		: do_ist ? 8'(ist) // (R13)
		: do_pscq ? 8'(psc_q) // (R18)
		: 8'h01; // (R17)
	wire [25:0] short_txt = ser_dec3(short_val);
	wire load_short = do_qry_mask | do_qry_evt | do_qry_stb | do_ist | do_pscq | opcq_fire;

	// ----------------------------------------
	// response stream
	// ----------------------------------------
	wire rsp_take = rsp_valid & rsp_ready;
	assign rsp_valid = mav;
	assign rsp_last = rsp_idx_q == rsp_len_q - 8'h01;
	assign lrn_idx = rsp_idx_q;
	always_comb begin
		case (rsp_st_q)
			ser_pkg::RSP_SHORT: rsp_data = rsp_buf_q[23:16];
			ser_pkg::RSP_IDN: rsp_data = IDN_STR[(`SER_IDN_LEN - 1 - int'(rsp_idx_q)) * 8 +: 8]; // (R12)
			ser_pkg::RSP_LRN: rsp_data = lrn_char; // (R15)
			default: rsp_data = 8'h00;
		endcase
	end
	assign cmd_ready = ~mav & ~opcq_pend_q;

	// response state machine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_st_q <= ser_pkg::RSP_IDLE;
			rsp_idx_q <= 8'h00;
			rsp_len_q <= 8'h00;
			rsp_buf_q <= 24'h00_0000;
		end else begin
			case (rsp_st_q)
				ser_pkg::RSP_IDLE: begin
					rsp_idx_q <= 8'h00;
					if (load_short) begin
						rsp_st_q <= ser_pkg::RSP_SHORT;
						rsp_len_q <= 8'(short_txt[25:24]);
						rsp_buf_q <= short_txt[23:0];
					end else if (do_idn) begin
						rsp_st_q <= ser_pkg::RSP_IDN; // (R12)
						rsp_len_q <= 8'(`SER_IDN_LEN);
					end else if (do_lrn) begin
						rsp_st_q <= ser_pkg::RSP_LRN; // (R15)
						rsp_len_q <= 8'(`SER_LRN_LEN);
					end
				end
				default: begin
					if (rsp_take) begin
						rsp_idx_q <= rsp_idx_q + 8'h01;
						rsp_buf_q <= {rsp_buf_q[15:0], 8'h00};
						if (rsp_last) begin
							rsp_st_q <= ser_pkg::RSP_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// mask registers and power-on clear flag
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			std_mask_q <= `SER_MASK_RST;
			a_mask_q <= `SER_MASK_RST;
			b_mask_q <= `SER_MASK_RST;
			sre_mask_q <= `SER_MASK_RST;
			ppe_mask_q <= `SER_MASK_RST;
			psc_q <= `SER_PSC_RST;
		end else begin
			std_mask_q <= wr_std ? cmd_arg : nv_wipe ? `SER_MASK_RST : std_mask_q; // (R02) (R03) (R04) (R05)
			a_mask_q <= wr_a ? cmd_arg : nv_wipe ? `SER_MASK_RST : a_mask_q; // (R02) (R03) (R05)
			b_mask_q <= wr_b ? cmd_arg : nv_wipe ? `SER_MASK_RST : b_mask_q; // (R02) (R03) (R05)
			sre_mask_q <= wr_sre ? cmd_arg : nv_wipe ? `SER_MASK_RST : sre_mask_q; // (R02) (R03) (R05)
			ppe_mask_q <= wr_ppe ? cmd_arg : nv_wipe ? `SER_MASK_RST : ppe_mask_q; // (R02) (R03) (R05)
			if (do_psc) begin
				psc_q <= cmd_arg[0]; // (R18) (R19)
			end
		end
	end

	// ----------------------------------------
	// event latches, edge history, request, completion
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			std_lat_q <= `SER_LATCH_RST;
			a_lat_q <= `SER_LATCH_RST;
			b_lat_q <= `SER_LATCH_RST;
			a_prev_q <= 8'h00;
			b_prev_q <= 8'h00;
			rqs_q <= 1'b0;
			mss_prev_q <= 1'b0;
			opc_pend_q <= 1'b0;
			opcq_pend_q <= 1'b0;
		end else begin
			std_lat_q <= std_lat_d;
			a_lat_q <= a_lat_d;
			b_lat_q <= b_lat_d;
			a_prev_q <= a_cond;
			b_prev_q <= b_cond;
			mss_prev_q <= mss;
			rqs_q <= (mss & ~mss_prev_q) | (rqs_q & ~poll_done & ~do_cls); // (R22)
			opc_pend_q <= do_opc | (opc_pend_q & exec_busy); // (R16)
			opcq_pend_q <= do_opcq | (opcq_pend_q & exec_busy); // (R17)
		end
	end

	// ----------------------------------------
	// setup and sequence slots
	// ----------------------------------------
	wire [SET_W-1:0] sav_data = slot_setup ? settings : {{(SET_W - SEQ_W){1'b0}}, settings[SEQ_W-1:0]}; // (R21)
	ser_slot_mem #(.W(SET_W), .D(`SER_SLOTS)) u_slots (
		.clk(clk),
		.rst(rst),
		.we(do_sav & ~slot_zero),
		.addr(cmd_arg),
		.wdata(sav_data),
		.rdata(mem_rdata)
	);

	// recall pulse registered on the same edge as the slot read, aligned with the read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rcl_q <= 1'b0;
			rcl_full_q <= 1'b0;
		end else begin
			rcl_q <= do_rcl & ~slot_zero;
			rcl_full_q <= slot_setup; // (R20)
		end
	end
	assign recall_valid = rcl_q;
	assign recall_full = rcl_full_q;
	assign recall_data = mem_rdata;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_mask_hold: assert property (!wr_std && !nv_wipe |=> $stable(std_mask_q)) // (R03)
		else $error("standard mask changed without a write");
	chk_mask_write: assert property (wr_sre |=> sre_mask_q == $past(cmd_arg)) // (R02)
		else $error("service request mask did not take the written value");
	chk_mask_wipe: assert property (nv_wipe && !wr_a |=> a_mask_q == 8'h00) // (R05)
		else $error("mask not cleared at shutdown with flag set");
	chk_edge_set: assert property (!A_FALL[0] && $rose(a_cond[0]) |=> a_lat_q[0]) // (R06)
		else $error("rising condition edge did not set event bit");
	chk_event_keep: assert property (b_lat_q[1] && !clr_b |=> b_lat_q[1] [*1]) // (R07)
		else $error("event bit dropped without read or clear");
	chk_read_keep: assert property (clr_a |=> a_lat_q == $past(a_set)) // (R08)
		else $error("read-clear lost a new event or kept an old one");
	chk_cls_all: assert property (do_cls && std_set == 8'h00 && a_set == 8'h00 && b_set == 8'h00
		|=> std_lat_q == 8'h00 && a_lat_q == 8'h00 && b_lat_q == 8'h00) // (R09)
		else $error("clear-status left an event latch set");
	chk_cme_set: assert property (cmd_bad |=> std_lat_q[`SER_ESR_CME]) // (R11)
		else $error("command error bit not set");
	chk_opc_wait: assert property (do_opc ##1 exec_busy [*2] |-> !opc_fire && opc_pend_q) // (R16)
		else $error("operation complete fired while busy");
	chk_ist_nobus: assert property (!gpib_fitted |-> ist) // (R14)
		else $error("individual status not one without parallel bus");
	chk_stb_sum: assert property (stb[`SER_STB_ESB] == |(std_lat_q & std_mask_q) && stb[`SER_STB_A] == a_sum) // (R23)
		else $error("status byte summary bit wrong");
	chk_cls_rqs: assert property (do_cls && !(mss && !mss_prev_q) |=> !srq) // (R22)
		else $error("service request survived clear-status");

endmodule : ser_status

//--- tb/ser_host.sv
// ----------------------------------------
// remote controller issuing commands
// ----------------------------------------
module ser_host (
	input wire logic clk, // instrument clock
	output logic cmd_valid, // command present
	input wire logic cmd_ready, // command taken when high
	output ser_pkg::ser_cmd_t cmd_code, // command code
	output ser_pkg::ser_sel_t cmd_sel, // register selector
	output logic [7:0] cmd_arg, // numeric argument
	input wire logic rsp_valid, // response character valid
	input wire logic rsp_last, // last response character
	input wire logic [7:0] rsp_data, // response character
	input wire logic [7:0] lrn_idx, // learn character index
	output logic [7:0] lrn_char // learn character
);
	timeunit 1ns;
	timeprecision 1ps;

	// learn formatter answers in the same cycle with a known pattern
	assign lrn_char = 8'h41 + {4'h0, lrn_idx[3:0]};

	// idle command port at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code = ser_pkg::CMD_NOP;
		cmd_sel = ser_pkg::SEL_STD;
		cmd_arg = 8'h00;
	end

	// drive at a falling edge once ready, hold across the taking edge
	task automatic send(input ser_pkg::ser_cmd_t c, input ser_pkg::ser_sel_t s, input logic [7:0] a);
		int n;
		n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_sel = s;
		cmd_arg = a;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask : send

	// query and gather characters, each taken at the next rising edge
	task automatic query(input ser_pkg::ser_cmd_t c, input ser_pkg::ser_sel_t s, input logic [7:0] a,
		output string r);
		int n;
		r = "";
		n = 0;
		send(c, s, a);
		while (n < 400) begin
			if (rsp_valid === 1'b1) begin
				r = {r, $sformatf("%c", rsp_data)};
				if (rsp_last === 1'b1) begin
					break;
				end
			end
			@(negedge clk);
			n++;
		end
	endtask : query
endmodule : ser_host

//--- tb/ser_status_tb.sv
`include "ser_cfg.svh"

module ser_status_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_ready, rsp_valid, rsp_last, srq, ist, recall_valid, recall_full;
	logic cmd_bad, exec_busy, pwr_down;
	logic gpib = 1'b0;
	ser_pkg::ser_cmd_t cmd_code;
	ser_pkg::ser_sel_t cmd_sel;
	logic [7:0] cmd_arg, a_cond, rsp_data, lrn_idx, lrn_char, stb;
	logic [63:0] settings, rec_data;
	int err_total = 0;
	int compares = 0;
	int mask_m[5];
	int a_lat;
	logic [31:0] rng = 32'h0000_0021;
	string s;

	// ----------------------------------------
	// clock, design and controller
	// ----------------------------------------
	always #5 clk = ~clk;

	ser_status i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_arg(cmd_arg), .cmd_bad(cmd_bad),
		.exec_busy(exec_busy), .std_evt(8'h00), .a_cond(a_cond), .b_cond(a_cond), .pwr_down(pwr_down),
		.poll_done(1'b0), .gpib_fitted(gpib), .rsp_valid(rsp_valid), .rsp_ready(1'b1),
		.rsp_data(rsp_data), .rsp_last(rsp_last), .lrn_idx(lrn_idx), .lrn_char(lrn_char), .stb(stb),
		.srq(srq), .ist(ist), .settings(settings), .recall_valid(recall_valid),
		.recall_full(recall_full), .recall_data(rec_data));

	ser_host i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_sel(cmd_sel), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
		.rsp_data(rsp_data), .lrn_idx(lrn_idx), .lrn_char(lrn_char));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	// decimal query compared with the model value
	task automatic qchk(input ser_pkg::ser_cmd_t c, input int sel, input int expv, input string msg);
		string r;
		i_host.query(c, ser_pkg::ser_sel_t'(sel), 8'h00, r);
		chk(r == $sformatf("%0d", expv), msg);
	endtask : qchk

	task automatic pulse_in(input int which);
		@(negedge clk);
		if (which == 0) cmd_bad = 1'b1;
		else pwr_down = 1'b1;
		@(negedge clk);
		cmd_bad = 1'b0;
		pwr_down = 1'b0;
	endtask : pulse_in

	task automatic summarize();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// watchdog cuts a hang short
	initial begin
		#200000;
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] r;
		logic [63:0] sv;
		int i;
		int j;
		cmd_bad = 1'b0;
		exec_busy = 1'b0;
		pwr_down = 1'b0;
		a_cond = 8'h00;
		settings = 64'h0000_0000_0000_0000;
		a_lat = 0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		// random masks, read back, then a zero write
		for (i = 0; i < 5; i++) begin
			mask_m[i] = int'(rnd() & 32'h0000_00ff);
			i_host.send(ser_pkg::CMD_SET_MASK, ser_pkg::ser_sel_t'(i), 8'(mask_m[i]));
		end
		for (i = 0; i < 5; i++) qchk(ser_pkg::CMD_QRY_MASK, i, mask_m[i], "mask readback");
		mask_m[1] = mask_m[1] | 1;
		i_host.send(ser_pkg::CMD_SET_MASK, ser_pkg::SEL_A, 8'(mask_m[1]));
		i_host.send(ser_pkg::CMD_SET_MASK, ser_pkg::SEL_B, 8'h00);
		mask_m[2] = 0;
		qchk(ser_pkg::CMD_QRY_MASK, 2, 0, "zero write");
		// event A edge latches and holds after the condition drops
		r = 8'(rnd()) | 8'h01;
		@(negedge clk);
		a_cond = r;
		@(negedge clk);
		a_cond = 8'h00;
		a_lat = int'(r);
		@(negedge clk);
		chk(stb[`SER_STB_A] === ((a_lat & mask_m[1]) != 0), "event a summary");
		qchk(ser_pkg::CMD_QRY_EVT, 1, a_lat, "event a held");
		// new edge during the read-clear is kept
		r = 8'(rnd()) | 8'h03;
		fork
			qchk(ser_pkg::CMD_QRY_EVT, 1, 0, "event a cleared by read");
			begin
				@(negedge clk);
				a_cond = r;
			end
		join
		a_cond = 8'h00;
		qchk(ser_pkg::CMD_QRY_EVT, 1, int'(r), "event kept during read");
		// command error and operation complete
		i_host.send(ser_pkg::CMD_SET_MASK, ser_pkg::SEL_STD, 8'h20);
		mask_m[0] = 32;
		pulse_in(0);
		@(negedge clk);
		chk(stb[`SER_STB_ESB] === 1'b1, "standard summary");
		chk(srq === ((mask_m[3] & 8'h34) != 0), "service request");
		exec_busy = 1'b1;
		i_host.send(ser_pkg::CMD_OPC, ser_pkg::SEL_STD, 8'h00);
		qchk(ser_pkg::CMD_QRY_EVT, 0, 32, "command error only");
		// completion query waits until the busy level drops
		fork
			qchk(ser_pkg::CMD_OPC_Q, 0, 1, "operation complete query");
			begin
				repeat (4) @(negedge clk);
				exec_busy = 1'b0;
			end
		join
		repeat (3) @(negedge clk);
		qchk(ser_pkg::CMD_QRY_EVT, 0, 1, "operation complete");
		// clear status empties latches, keeps masks
		@(negedge clk);
		a_cond = r;
		cmd_bad = 1'b1;
		@(negedge clk);
		a_cond = 8'h00;
		cmd_bad = 1'b0;
		i_host.send(ser_pkg::CMD_CLS, ser_pkg::SEL_STD, 8'h00);
		@(negedge clk);
		chk((stb & 8'h6c) === 8'h00 && srq === 1'b0, "status byte cleared");
		qchk(ser_pkg::CMD_QRY_EVT, 0, 0, "standard cleared");
		qchk(ser_pkg::CMD_QRY_EVT, 1, 0, "event a cleared");
		for (i = 0; i < 5; i++) qchk(ser_pkg::CMD_QRY_MASK, i, mask_m[i], "mask kept");
		// power-on clear flag decides whether shutdown clears masks
		for (i = 0; i < 2; i++) begin
			i_host.send(ser_pkg::CMD_PSC, ser_pkg::SEL_STD, 8'(i));
			i_host.send(ser_pkg::CMD_CLS, ser_pkg::SEL_STD, 8'h00);
			qchk(ser_pkg::CMD_PSC_Q, 0, i, "flag readback");
			pulse_in(1);
			if (i == 1) mask_m = '{default: 0};
			for (j = 0; j < 5; j++) qchk(ser_pkg::CMD_QRY_MASK, j, mask_m[j], "mask at shutdown");
		end
		// fixed replies
		i_host.query(ser_pkg::CMD_IST, ser_pkg::SEL_STD, 8'h00, s);
		chk(s == "1", "individual status");
		i_host.query(ser_pkg::CMD_IDN, ser_pkg::SEL_STD, 8'h00, s);
		chk(s.len() == 49, "identity length");
		i_host.query(ser_pkg::CMD_LRN, ser_pkg::SEL_STD, 8'h00, s);
		chk(s.len() == 202 && s[201] == 8'h4a, "learn text");
		// parallel bus fitted: poll mask is zero after the wipe
		gpib = 1'b1;
		qchk(ser_pkg::CMD_IST, 0, 0, "individual status with bus");
		qchk(ser_pkg::CMD_QRY_STB, 0, 16, "status byte query");
		// setup and sequence slots
		sv = {rnd(), rnd()};
		settings = sv;
		i_host.send(ser_pkg::CMD_SAV, ser_pkg::SEL_STD, 8'h03);
		repeat (2) @(negedge clk);
		settings = ~sv;
		i_host.send(ser_pkg::CMD_SAV, ser_pkg::SEL_STD, 8'h14);
		repeat (2) @(negedge clk);
		settings = 64'h0000_0000_0000_0000;
		i_host.send(ser_pkg::CMD_RCL, ser_pkg::SEL_STD, 8'h03);
		chk(recall_valid === 1'b1 && recall_full === 1'b1 && rec_data === sv, "setup recall");
		i_host.send(ser_pkg::CMD_RCL, ser_pkg::SEL_STD, 8'h14);
		chk(recall_valid === 1'b1 && recall_full === 1'b0 && rec_data === {24'h00_0000, ~sv[39:0]},
			"sequence recall");
		repeat (3) @(negedge clk);
		summarize();
	end
endmodule : ser_status_tb
